/* design/peu_edge_detect.sv */
// Per-pin synchroniser and configurable edge detector
`timescale 1ns/1ps
`default_nettype none

module peu_edge_detect #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Pins and configuration
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] bufDisable,
    input wire logic [2*WIDTH-1:0] edgeMode,
    // Results
    output logic [WIDTH-1:0] pinLevel,
    output logic [WIDTH-1:0] edgeHit
);

    logic [WIDTH-1:0] syncA;
    logic [WIDTH-1:0] syncB;
    logic [WIDTH-1:0] prevLevel;

    // ------------------------------------------------------------
    // Two-stage synchroniser, then one history stage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            syncA <= '0;
            syncB <= '0;
            prevLevel <= '0;
        end else if (ce) begin
            syncA <= pinIn;
            syncB <= syncA;
            prevLevel <= syncB;
        end
    end

    // Disabled input buffer reads as low; no edges reach the detector
    assign pinLevel = syncB & ~bufDisable;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gPin
            logic rise;
            logic fall;
            logic [1:0] mode;
            assign mode = edgeMode[2*i +: 2];
            assign rise = pinLevel[i] & ~prevLevel[i] & ~bufDisable[i];
            assign fall = ~pinLevel[i] & prevLevel[i] & ~bufDisable[i];
            // Edge only, never level: a held pin fires once
            always_comb begin
                case (mode)
                    peu_pkg::EDGE_RISE: edgeHit[i] = rise;
                    peu_pkg::EDGE_FALL: edgeHit[i] = fall;
                    peu_pkg::EDGE_BOTH: edgeHit[i] = rise | fall;
                    default: edgeHit[i] = 1'b0;
                endcase
            end
        end
    endgenerate

endmodule // peu_edge_detect

`default_nettype wire

/* design/peu_port_unit.sv */
// Port edge interrupt unit: APB registers, status latching, pad config
//
// Summary of operation
// - Eight pins form one port with its own interrupt request line.
// - Each pin selects rising, falling, both edges or no detection.
// - A matching edge sets the pin status bit and raises the request.
// - A per-pin status register tells software which pin fired.
// - Detection runs on the always-on clock, independent of sleep state; this design stops detection while ce is low.
// - Only edges are detected; no level-sensitive interrupt mode exists.
// - Port-wide input threshold select, CMOS by default, LVTTL optional.
// - Any pin input buffer can be disabled whatever its drive mode.
// - Each special pin selects supply-level or regulated high output.
// - Regulated output mode blocks resistive pull-up and pull-down drive.
// - Special pins pair up sharing one four-way input threshold reference.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module peu_port_unit #(
    parameter int WIDTH = 8
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [3*WIDTH-1:0] driveReq,
    // Pad configuration
    output peu_pkg::peu_padcfg_t padCfg,
    output logic [3*WIDTH-1:0] driveOut,
    // Interrupt
    output logic portIrq,
    output logic irq
);

    typedef enum logic [1:0] {
        PEU_IDLE = 2'b01,
        PEU_DONE = 2'b10
    } peu_bus_t;

    peu_bus_t busState;
    logic [2*WIDTH-1:0] edgeMode;
    logic [WIDTH-1:0] status;
    logic [WIDTH-1:0] mask;
    logic lvttlSel;
    logic [WIDTH-1:0] bufDisable;
    logic [WIDTH-1:0] regOutSel;
    logic [WIDTH-1:0] refThr;
    logic [WIDTH-1:0] pinLevel;
    logic [WIDTH-1:0] edgeHit;
    logic access;
    logic wrEn;
    logic rdStatus;
    logic mapped;
    logic [31:0] next_prdata;

    // Decode used by both the write path and the read path
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    peu_edge_detect #(
        .WIDTH(WIDTH)
    ) uDetect (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .pinIn(pinIn),
        .bufDisable(bufDisable),
        .edgeMode(edgeMode),
        .pinLevel(pinLevel),
        .edgeHit(edgeHit)
    );

    // ------------------------------------------------------------
    // APB handshake: one wait state, answer registered
    // ------------------------------------------------------------
    assign access = psel & penable & (busState == PEU_IDLE);
    assign mapped = hit(paddr, peu_pkg::OFF_MODE_LO)
        | hit(paddr, peu_pkg::OFF_MODE_HI)
        | hit(paddr, peu_pkg::OFF_STATUS)
        | hit(paddr, peu_pkg::OFF_MASK)
        | hit(paddr, peu_pkg::OFF_INCFG)
        | hit(paddr, peu_pkg::OFF_SIOCFG)
        | hit(paddr, peu_pkg::OFF_STATE);
    assign wrEn = access & pwrite & mapped;
    assign rdStatus = access & ~pwrite & hit(paddr, peu_pkg::OFF_STATUS);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            busState <= PEU_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            case (busState)
                PEU_IDLE: begin
                    if (access) begin
                        busState <= PEU_DONE;
                        pready <= 1'b1;
                        pslverr <= ~mapped;
                    end
                end
                PEU_DONE: begin
                    busState <= PEU_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    busState <= PEU_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        next_prdata = peu_pkg::RST_ZERO;
        if (hit(paddr, peu_pkg::OFF_MODE_LO)) begin
            next_prdata[WIDTH-1:0] = edgeMode[WIDTH-1:0];
        end else if (hit(paddr, peu_pkg::OFF_MODE_HI)) begin
            next_prdata[WIDTH-1:0] = edgeMode[2*WIDTH-1:WIDTH];
        end else if (hit(paddr, peu_pkg::OFF_STATUS)) begin
            next_prdata[WIDTH-1:0] = status;
        end else if (hit(paddr, peu_pkg::OFF_MASK)) begin
            next_prdata[WIDTH-1:0] = mask;
        end else if (hit(paddr, peu_pkg::OFF_INCFG)) begin
            next_prdata[peu_pkg::INCFG_LVTTL_BIT] = lvttlSel;
            next_prdata[peu_pkg::INCFG_BUFOFF_LSB +: WIDTH] = bufDisable;
        end else if (hit(paddr, peu_pkg::OFF_SIOCFG)) begin
            next_prdata[peu_pkg::SIO_REGOUT_LSB +: WIDTH] = regOutSel;
            next_prdata[peu_pkg::SIO_THR_LSB +: WIDTH] = refThr;
        end else if (hit(paddr, peu_pkg::OFF_STATE)) begin
            next_prdata[WIDTH-1:0] = pinLevel;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata <= peu_pkg::RST_ZERO;
        end else if (ce) begin
            if (access && !pwrite) begin
                prdata <= next_prdata;
            end else if (busState == PEU_DONE) begin
                prdata <= peu_pkg::RST_ZERO;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            edgeMode <= '0;
            mask <= '0;
        end else if (ce && wrEn) begin
            if (hit(paddr, peu_pkg::OFF_MODE_LO)) begin
                edgeMode[WIDTH-1:0] <= pwdata[WIDTH-1:0];
            end
            if (hit(paddr, peu_pkg::OFF_MODE_HI)) begin
                edgeMode[2*WIDTH-1:WIDTH] <= pwdata[WIDTH-1:0];
            end
            if (hit(paddr, peu_pkg::OFF_MASK)) begin
                mask <= pwdata[WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lvttlSel <= 1'b0;
            bufDisable <= '0;
            regOutSel <= '0;
            refThr <= '0;
        end else if (ce && wrEn) begin
            if (hit(paddr, peu_pkg::OFF_INCFG)) begin
                lvttlSel <= pwdata[peu_pkg::INCFG_LVTTL_BIT];
                bufDisable <= pwdata[peu_pkg::INCFG_BUFOFF_LSB +: WIDTH];
            end
            if (hit(paddr, peu_pkg::OFF_SIOCFG)) begin
                regOutSel <= pwdata[peu_pkg::SIO_REGOUT_LSB +: WIDTH];
                refThr <= pwdata[peu_pkg::SIO_THR_LSB +: WIDTH];
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky status: cleared by a read or a write of one; set wins
    // ------------------------------------------------------------
    logic [WIDTH-1:0] clrMask;
    always_comb begin
        clrMask = '0;
        if (rdStatus) begin
            clrMask = {WIDTH{1'b1}};
        end else if (wrEn && hit(paddr, peu_pkg::OFF_STATUS)) begin
            clrMask = pwdata[WIDTH-1:0];
        end
    end

    // Status updates only while ce is high; detection halts while ce is low
    always_ff @(posedge clk) begin
        if (!resetn) begin
            status <= '0;
        end else if (ce) begin
            status <= (status & ~clrMask) | edgeHit;
        end
    end

    // ------------------------------------------------------------
    // Interrupt outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            portIrq <= 1'b0;
            irq <= 1'b0;
        end else if (ce) begin
            portIrq <= |((status & ~clrMask) | edgeHit);
            irq <= |(((status & ~clrMask) | edgeHit) & mask);
        end
    end

    // ------------------------------------------------------------
    // Pad configuration and drive gating
    // ------------------------------------------------------------
    // Threshold selects are one two-bit code per pin pair
    always_ff @(posedge clk) begin
        if (!resetn) begin
            padCfg <= '0;
        end else if (ce) begin
            padCfg.lvttlSel <= lvttlSel;
            padCfg.bufDisable <= bufDisable;
            padCfg.regOutSel <= regOutSel;
            padCfg.refThr <= refThr;
        end
    end

    genvar p;
    generate
        for (p = 0; p < WIDTH; p++) begin : gDrive
            logic [2:0] req;
            logic resistive;
            assign req = driveReq[3*p +: 3];
            assign resistive = (req == peu_pkg::DRIVE_PULL_UP)
                | (req == peu_pkg::DRIVE_PULL_DOWN)
                | (req == peu_pkg::DRIVE_PULL_BOTH);
            // Regulated mode falls back to strong drive
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    driveOut[3*p +: 3] <= '0;
                end else if (ce) begin
                    if (regOutSel[p] && resistive) begin
                        driveOut[3*p +: 3] <= peu_pkg::DRIVE_STRONG;
                    end else begin
                        driveOut[3*p +: 3] <= req;
                    end
                end
            end
        end
    endgenerate

endmodule // peu_port_unit

`default_nettype wire

/* shared/peu_pkg.sv */
// Package of constants and types for the port edge interrupt unit
`default_nettype none

package peu_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int PINS_PER_PORT = 8;

    // ------------------------------------------------------------
    // APB register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_MODE_LO = 8'h00;
    localparam logic [7:0] OFF_MODE_HI = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0c;
    localparam logic [7:0] OFF_INCFG = 8'h10;
    localparam logic [7:0] OFF_SIOCFG = 8'h14;
    localparam logic [7:0] OFF_STATE = 8'h18;

    // ------------------------------------------------------------
    // Edge detection modes, two bits per pin
    // ------------------------------------------------------------
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int INCFG_LVTTL_BIT = 0;
    localparam int INCFG_BUFOFF_LSB = 8;
    localparam int SIO_REGOUT_LSB = 0;
    localparam int SIO_THR_LSB = 8;
    localparam int SIO_THR_W = 2;

    // Special pin pair high-level input threshold selections
    localparam logic [1:0] THR_HALF_SUPPLY = 2'h0;
    localparam logic [1:0] THR_FOURTENTHS_SUPPLY = 2'h1;
    localparam logic [1:0] THR_HALF_REF = 2'h2;
    localparam logic [1:0] THR_FULL_REF = 2'h3;

    // Drive modes a pad may request; resistive ones are gated
    localparam logic [2:0] DRIVE_PULL_UP = 3'h2;
    localparam logic [2:0] DRIVE_PULL_DOWN = 3'h3;
    localparam logic [2:0] DRIVE_PULL_BOTH = 3'h6;
    localparam logic [2:0] DRIVE_STRONG = 3'h4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic lvttlSel;
        logic [7:0] bufDisable;
        logic [7:0] regOutSel;
        logic [7:0] refThr;
    } peu_padcfg_t;

endpackage

`default_nettype wire

/* tb/peu_pin_model.sv */
// Model of the pins and the interrupt controller around one port unit
`timescale 1ns/1ps
`default_nettype none

module peu_pin_model (
    // Clock
    input wire logic clk,
    // Wanted levels and request line
    input wire logic [7:0] level,
    input wire logic irq,
    // Pin levels and request count
    output logic [7:0] pinIn = 8'h00,
    output logic [7:0] irqEdges = 8'h00
);
    logic irqSeen = 1'b0;
    // Pins move just after an edge, like a source with no clock relation
    always_ff @(posedge clk) begin
        pinIn <= level;
    end
    // One request line per port; counted while the core would sleep
    always_ff @(posedge clk) begin
        irqSeen <= irq;
        if (irq && !irqSeen) begin
            irqEdges <= irqEdges + 8'h01;
        end
    end
endmodule // peu_pin_model

`default_nettype wire

/* tb/peu_port_monitor.sv */
// Port checker for the port edge interrupt unit
`timescale 1ns/1ps
`default_nettype none

module peu_port_monitor #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins, pads, requests
    input wire logic [WIDTH-1:0] pinIn,
    input wire peu_pkg::peu_padcfg_t padCfg,
    input wire logic [3*WIDTH-1:0] driveOut,
    input wire logic portIrq,
    input wire logic irq
);
    logic [7:0] prevReg;
    logic badDrive;
    logic stAcc;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    assign stAcc = psel && penable && !pready && paddr == peu_pkg::OFF_STATUS;
    // Held two cycles so a fresh mode change is not judged mid-update
    always_ff @(posedge clk) begin
        prevReg <= padCfg.regOutSel;
    end
    always_comb begin
        badDrive = 1'b0;
        for (int p = 0; p < 8; p++) begin
            if (prevReg[p] && padCfg.regOutSel[p] && driveOut[3*p+:3] inside
                {peu_pkg::DRIVE_PULL_UP, peu_pkg::DRIVE_PULL_DOWN,
                 peu_pkg::DRIVE_PULL_BOTH}) begin
                badDrive = 1'b1;
            end
        end
    end
    ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero");
    irq_has_port_a: assert property (irq |-> portIrq)
        else $error("irq without port request");
    irq_from_edge_a: assert property ($rose(portIrq) |->
        $past(pinIn, 3) != $past(pinIn, 4) || $past(pinIn, 4) != $past(pinIn, 5))
        else $error("request without pin edge");
    irq_clear_read_a: assert property ($fell(portIrq) && $past(resetn)
        |-> $past(stAcc))
        else $error("request dropped without status access");
    regout_no_pull_a: assert property (!badDrive)
        else $error("resistive drive in regulated mode");
    cover property ($rose(irq));
    cover property (pslverr);
    cover property ($fell(portIrq));
endmodule // peu_port_monitor

bind peu_port_unit peu_port_monitor #(.WIDTH(WIDTH)) mon_u (
    .clk, .resetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .pinIn, .padCfg, .driveOut, .portIrq, .irq
);

`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench of the port edge interrupt unit
`timescale 1ns/1ps
`default_nettype none

module testbench;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wd;
        logic [31:0] rd;
        logic err;
        logic [24:0] pad;
    } peu_reg_row_t;
    typedef struct packed {
        logic [7:0] pins;
        logic [7:0] st;
        logic pirq;
        logic mirq;
    } peu_edge_row_t;
    localparam peu_reg_row_t REGS [9] = '{
        '{8'h00, 32'hffff_0039, 32'h0000_0039, 1'b0, 25'h0},
        '{8'h04, 32'hffff_ffff, 32'h0000_00ff, 1'b0, 25'h0},
        '{8'h0c, 32'hffff_ff01, 32'h0000_0001, 1'b0, 25'h0},
        '{8'h10, 32'hffff_ffff, 32'h0000_ff01, 1'b0, 25'h1ff_0000},
        '{8'h10, 32'h0000_0000, 32'h0000_0000, 1'b0, 25'h0},
        '{8'h14, 32'h0000_e4a5, 32'h0000_e4a5, 1'b0, 25'h000_a5e4},
        '{8'h08, 32'hffff_ffff, 32'h0000_0000, 1'b0, 25'h000_a5e4},
        '{8'h18, 32'hffff_ffff, 32'h0000_0000, 1'b0, 25'h000_a5e4},
        '{8'h1c, 32'hffff_ffff, 32'h0000_0000, 1'b1, 25'h000_a5e4}};
    localparam peu_edge_row_t EDGES [5] = '{'{8'h0f, 8'h05, 1'b1, 1'b1},
        '{8'h00, 8'h06, 1'b1, 1'b0}, '{8'hf0, 8'hf0, 1'b1, 1'b0},
        '{8'hc0, 8'h30, 1'b1, 1'b0}, '{8'h00, 8'hc0, 1'b1, 1'b0}};
    localparam logic [2:0] CODES [4] = '{peu_pkg::DRIVE_PULL_UP,
        peu_pkg::DRIVE_PULL_DOWN, peu_pkg::DRIVE_PULL_BOTH,
        peu_pkg::DRIVE_STRONG};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pinLevel = 8'h00;
    logic [7:0] pinIn;
    logic [7:0] irqEdges;
    logic [23:0] driveReq = 24'h0;
    peu_pkg::peu_padcfg_t padCfg;
    logic [23:0] driveOut;
    logic portIrq;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    logic [2:0] e3;
    int fail_count = 0;
    int n_checks = 0;

    peu_port_unit #(.WIDTH(8)) dut_u (
        .clk, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pinIn, .driveReq, .padCfg, .driveOut,
        .portIrq, .irq
    );
    peu_pin_model pins_u (
        .clk, .level(pinLevel), .irq, .pinIn, .irqEdges
    );

    initial begin
        forever #50 clk = ~clk;
    end

    task check(input string name, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task settle(input logic [7:0] v);
        pinLevel <= v;
        repeat (8) @(posedge clk);
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run is near 300 cycles; the guard allows fifty times that
    initial begin
        #(100ns * 15000);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 0; a <= 8'h18; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            check("reset value", rdat, peu_pkg::RST_ZERO);
        end
        foreach (REGS[i]) begin
            apb(1'b1, REGS[i].addr, REGS[i].wd);
            check("write err", 32'(rerr), 32'(REGS[i].err));
            apb(1'b0, REGS[i].addr, 32'h0);
            check("read data", rdat, REGS[i].rd);
            check("pad config", 32'(padCfg), 32'(REGS[i].pad));
        end
        $display("test registers done");
        foreach (CODES[k]) begin
            driveReq <= {8{CODES[k]}};
            repeat (3) @(posedge clk);
            for (int p = 0; p < 8; p++) begin
                e3 = (8'ha5 >> p) & 8'h01 ? peu_pkg::DRIVE_STRONG : CODES[k];
                check("drive", 32'(driveOut[3*p+:3]), 32'(e3));
            end
        end
        $display("test drive gating done");
        foreach (EDGES[i]) begin
            settle(EDGES[i].pins);
            check("portIrq", 32'(portIrq), 32'(EDGES[i].pirq));
            check("irq", 32'(irq), 32'(EDGES[i].mirq));
            apb(1'b0, peu_pkg::OFF_STATUS, 32'h0);
            check("status", rdat, 32'(EDGES[i].st));
            apb(1'b0, peu_pkg::OFF_STATUS, 32'h0);
            check("status again", rdat, 32'h0);
            check("portIrq clear", 32'(portIrq), 32'h0);
        end
        check("irq count", 32'(irqEdges), 32'h1);
        $display("test edges done");
        settle(8'h30);
        apb(1'b1, peu_pkg::OFF_STATUS, 32'h10);
        apb(1'b0, peu_pkg::OFF_STATUS, 32'h0);
        check("w1c status", rdat, 32'h20);
        settle(8'h00);
        apb(1'b0, peu_pkg::OFF_STATUS, 32'h0);
        apb(1'b1, peu_pkg::OFF_INCFG, 32'h1000);
        settle(8'h30);
        apb(1'b0, peu_pkg::OFF_STATE, 32'h0);
        check("pin state", rdat, 32'h20);
        apb(1'b0, peu_pkg::OFF_STATUS, 32'h0);
        check("buffer off status", rdat, 32'h20);
        settle(8'h00);
        apb(1'b0, peu_pkg::OFF_STATUS, 32'h0);
        apb(1'b1, peu_pkg::OFF_INCFG, 32'h0);
        $display("test clear and buffer done");
        ce <= 1'b0;
        settle(8'h01);
        settle(8'h00);
        ce <= 1'b1;
        check("frozen request", 32'(portIrq), 32'h0);
        $display("test clock enable done");
        settle(8'h01);
        check("irq before reset", 32'(irq), 32'h1);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        check("portIrq reset", 32'(portIrq), 32'h0);
        check("pad reset", 32'(padCfg), 32'h0);
        apb(1'b0, peu_pkg::OFF_MODE_LO, 32'h0);
        check("mode reset", rdat, 32'h0);
        settle(8'h00);
        $display("test reset done");
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
